// ---- mc_counter16.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdog_defines.svh"

module mc_counter16
#(
   parameter int CW = 16
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Slow clock and control
   input wire logic lf_tick,
   input wire logic enable,
   input wire wdog_pkg::chan_cfg_t cfg,
   input wire logic [CW-1:0] match_value,
   input wire logic flag_clear,
   // State and events
   output logic [CW-1:0] count,
   output logic int_flag,
   output logic reset_event
);

   logic [CW-1:0] count_ff;
   logic flag_ff;
   logic [1:0] miss_ff;
   logic hit;
   logic ev;
   logic irq_mode;

   assign hit = (count_ff == match_value);
   assign ev = lf_tick & enable & hit;
   assign irq_mode = (cfg.match_action == wdog_pkg::act_irq) ||
                     (cfg.match_action == wdog_pkg::act_irq_then_reset);

   // Up counter on the slow clock, optional clear on match
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= '0;
      else if (lf_tick && enable)
      begin
         if (hit && cfg.clear_on_match)
            count_ff <= '0;
         else
            count_ff <= count_ff + 1'b1;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_ff <= 1'b0;
      else if (ev && irq_mode)
         flag_ff <= 1'b1;
      else if (flag_clear)
         flag_ff <= 1'b0;
   end

   // Matches seen since the flag was last handled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         miss_ff <= 2'h0;
      else if (ev && cfg.match_action == wdog_pkg::act_irq_then_reset)
         miss_ff <= (flag_clear || miss_ff == `WDOG_MISS_LIMIT) ? 2'h1 : miss_ff + 2'h1;
      else if (flag_clear)
         miss_ff <= 2'h0;
   end

   // Reset request: plain reset mode, or third unhandled match
   assign reset_event = ev && ((cfg.match_action == wdog_pkg::act_reset) ||
                        (cfg.match_action == wdog_pkg::act_irq_then_reset &&
                         !flag_clear && miss_ff == `WDOG_MISS_LIMIT));
   assign count = count_ff;
   assign int_flag = flag_ff;

endmodule
`default_nettype wire

// ---- watchdog_and_multicounter_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdog_defines.svh"
// Overview of operation
// - Debug attached: reset blocked, interrupt raised instead
// - Writing 1 to flag feeds, counter untouched
// - Match never stops or clears free counter
// - Reset period about two wraps plus match
// - Lock code 3 protects enable, match, clocks
// - Interrupt to CPU active, wakeup controller asleep
// - Hibernate match wakeup gives full device reset
// - Match interrupt passes only when mask set
// - Two 16-bit multi-counters on slow clock
// - Counter 0 low half, counter 1 high
// - Two-bit action: none, irq, reset, combined
// - Combined: third unhandled match resets device
// - Clear-on-match gives period match plus one
// - New match value applies on the second slow edge after the write
// - Free counter counts ticks, wraps, flags matches
// - Ignored bits mask MSbs, capped at twelve
// - Third uncleared free match resets device
// - Lock codes: none, clear0, clear1, set both

module watchdog_and_multicounter_timer
#(
   parameter int CW = 16,
   parameter int CHANNELS = 2
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDOG_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Slow clock ticks, one pclk cycle per rising edge
   input wire logic osc_tick,
   input wire logic lf_tick,
   // Device state
   input wire logic debug_attached,
   input wire wdog_pkg::power_mode_t power_mode,
   // Interrupt routing and reset
   output logic cpu_irq,
   output logic wic_irq,
   output logic device_reset_req,
   output logic [CHANNELS-1:0] counter_interrupt_request,
   // Clock controls owned by the watchdog lock
   output logic osc_enable,
   output logic [1:0] lf_select
);

   // Bus decode
   logic setup;
   logic wr;
   logic hit_ok;
   logic [31:0] rd_data;
   logic [31:0] prdata_ff;
   logic locked;

   // Free-running watchdog state
   logic watchdog_enable_bit_ff;
   logic [1:0] config_lock_field_ff;
   logic [CW-1:0] fr_count_ff;
   logic [CW-1:0] fr_match_ff;
   logic [3:0] ignore_ff;
   logic match_interrupt_flag_ff;
   logic blocked_flag_ff;
   logic mask_ff;
   logic osc_en_ff;
   logic [1:0] lf_sel_ff;
   logic [1:0] miss_ff;
   logic [3:0] ign_eff;
   logic [CW-1:0] cmp_mask;
   logic fr_run;
   logic fr_ev;
   logic feed;
   logic fr_reset;
   logic hib_reset;
   logic any_reset;
   logic reset_ff;

   // Multi-counter state
   logic [CHANNELS-1:0] mc_en_ff;
   wdog_pkg::chan_cfg_t [CHANNELS-1:0] mc_cfg_ff;
   logic [CHANNELS*CW-1:0] mc_match_sw_ff;
   logic [CHANNELS*CW-1:0] mc_match_eff_ff;
   wdog_pkg::match_sync_t sync_ff;
   wdog_pkg::match_sync_t nxt_sync;
   logic [CHANNELS*CW-1:0] mc_count;
   logic [CHANNELS-1:0] mc_flag;
   logic [CHANNELS-1:0] mc_reset;
   logic [CHANNELS-1:0] mc_clear;
   logic irq_level;

   // Zero wait state slave: write at the access edge
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & hit_ok;
   assign pready = 1'b1;
   assign locked = |config_lock_field_ff;

   // Address decode for the unmapped-address error
   always_comb
   begin
      unique case (paddr)
         `WDOG_OFF_CTL, `WDOG_OFF_CNT, `WDOG_OFF_MATCH, `WDOG_OFF_INTR,
         `WDOG_OFF_MASK, `WDOG_OFF_OSC, `WDOG_OFF_CLKSEL, `WDOG_OFF_MC_CTL,
         `WDOG_OFF_MC_CFG, `WDOG_OFF_MC_CNT, `WDOG_OFF_MC_MATCH, `WDOG_OFF_MC_INTR:
            hit_ok = 1'b1;
         default:
            hit_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit_ok;

   // Read mux; counts are sampled whole in one cycle, so no tearing
   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (paddr)
         `WDOG_OFF_CTL:
         begin
            rd_data[`WDOG_CTL_EN] = watchdog_enable_bit_ff;
            rd_data[`WDOG_LOCK_HI:`WDOG_LOCK_LO] = config_lock_field_ff;
         end
         `WDOG_OFF_CNT:
            rd_data[CW-1:0] = fr_count_ff;
         `WDOG_OFF_MATCH:
         begin
            rd_data[CW-1:0] = fr_match_ff;
            rd_data[`WDOG_IGN_HI:`WDOG_IGN_LO] = ignore_ff;
         end
         `WDOG_OFF_INTR:
         begin
            rd_data[`WDOG_INTR_MATCH] = match_interrupt_flag_ff;
            rd_data[`WDOG_INTR_BLOCKED] = blocked_flag_ff;
         end
         `WDOG_OFF_MASK:
            rd_data[`WDOG_INTR_MATCH] = mask_ff;
         `WDOG_OFF_OSC:
            rd_data[`WDOG_OSC_EN] = osc_en_ff;
         `WDOG_OFF_CLKSEL:
            rd_data[1:0] = lf_sel_ff;
         `WDOG_OFF_MC_CTL:
         begin
            rd_data[0] = mc_en_ff[0];
            rd_data[`WDOG_MC_EN1] = mc_en_ff[1];
         end
         `WDOG_OFF_MC_CFG:
         begin
            rd_data[2:0] = mc_cfg_ff[0];
            rd_data[`WDOG_MC_CFG1+2:`WDOG_MC_CFG1] = mc_cfg_ff[1];
         end
         `WDOG_OFF_MC_CNT:
            rd_data = mc_count;
         `WDOG_OFF_MC_MATCH:
            rd_data = mc_match_sw_ff;
         `WDOG_OFF_MC_INTR:
            rd_data[CHANNELS-1:0] = mc_flag;
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (setup && !pwrite)
         prdata_ff <= rd_data;
   end
   assign prdata = prdata_ff;

   // Lock field: always writable, locks on reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         config_lock_field_ff <= `WDOG_LOCK_RST;
      else if (wr && paddr == `WDOG_OFF_CTL)
      begin
         unique case (pwdata[`WDOG_LOCK_HI:`WDOG_LOCK_LO])
            `WDOG_LOCK_CLR0:
               config_lock_field_ff <= config_lock_field_ff & 2'h2;
            `WDOG_LOCK_CLR1:
               config_lock_field_ff <= config_lock_field_ff & 2'h1;
            `WDOG_LOCK_SET:
               config_lock_field_ff <= `WDOG_LOCK_SET;
            default:
               config_lock_field_ff <= config_lock_field_ff;
         endcase
      end
   end

   // Protected configuration: ignored while any lock bit is set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_enable_bit_ff <= 1'b0;
         fr_match_ff <= `WDOG_MATCH_RST;
         ignore_ff <= 4'h0;
         osc_en_ff <= 1'b0;
         lf_sel_ff <= 2'h0;
      end
      else if (wr && !locked)
      begin
         if (paddr == `WDOG_OFF_CTL)
            watchdog_enable_bit_ff <= pwdata[`WDOG_CTL_EN];
         if (paddr == `WDOG_OFF_MATCH)
         begin
            fr_match_ff <= pwdata[CW-1:0];
            ignore_ff <= pwdata[`WDOG_IGN_HI:`WDOG_IGN_LO];
         end
         if (paddr == `WDOG_OFF_OSC)
            osc_en_ff <= pwdata[`WDOG_OSC_EN];
         if (paddr == `WDOG_OFF_CLKSEL)
            lf_sel_ff <= pwdata[1:0];
      end
   end
   assign osc_enable = osc_en_ff;
   assign lf_select = lf_sel_ff;

   // Mask and multi-counter control are not under the watchdog lock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_ff <= 1'b0;
         mc_en_ff <= '0;
         mc_cfg_ff <= '0;
         mc_match_sw_ff <= '0;
      end
      else if (wr)
      begin
         if (paddr == `WDOG_OFF_MASK)
            mask_ff <= pwdata[`WDOG_INTR_MATCH];
         if (paddr == `WDOG_OFF_MC_CTL)
            mc_en_ff <= {pwdata[`WDOG_MC_EN1], pwdata[0]};
         if (paddr == `WDOG_OFF_MC_CFG)
         begin
            mc_cfg_ff[0] <= wdog_pkg::chan_cfg_t'(pwdata[2:0]);
            mc_cfg_ff[1] <= wdog_pkg::chan_cfg_t'(pwdata[`WDOG_MC_CFG1+2:`WDOG_MC_CFG1]);
         end
         if (paddr == `WDOG_OFF_MC_MATCH)
            mc_match_sw_ff <= pwdata;
      end
   end

   // Free-running counter runs only with enable and oscillator on
   assign fr_run = watchdog_enable_bit_ff & osc_en_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fr_count_ff <= '0;
      else if (osc_tick && fr_run)
         fr_count_ff <= fr_count_ff + 1'b1;
   end

   // Masked comparison; the counter itself stays full width
   assign ign_eff = (ignore_ff > `WDOG_IGN_MAX) ? `WDOG_IGN_MAX : ignore_ff;
   assign cmp_mask = {CW{1'b1}} >> ign_eff;
   assign fr_ev = osc_tick & fr_run &
                  ((fr_count_ff & cmp_mask) == (fr_match_ff & cmp_mask));
   assign feed = wr & (paddr == `WDOG_OFF_INTR) & pwdata[`WDOG_INTR_MATCH];

   // Match flag: the match wins over a feed in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         match_interrupt_flag_ff <= 1'b0;
      else if (fr_ev)
         match_interrupt_flag_ff <= 1'b1;
      else if (feed)
         match_interrupt_flag_ff <= 1'b0;
   end

   // Matches since the last feed; a feed clears this and the match flag, not the count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         miss_ff <= 2'h0;
      else if (fr_ev)
         miss_ff <= (feed || miss_ff == `WDOG_MISS_LIMIT) ? 2'h1 : miss_ff + 2'h1;
      else if (feed)
         miss_ff <= 2'h0;
   end

   // Third unhandled match resets; hibernate wakeup also resets
   assign fr_reset = fr_ev & ~feed & (miss_ff == `WDOG_MISS_LIMIT);
   assign hib_reset = fr_ev & (power_mode == wdog_pkg::pm_hibernate);
   assign any_reset = fr_reset | hib_reset | (|mc_reset);

   // Debug probe turns a reset into a sticky interrupt flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blocked_flag_ff <= 1'b0;
      else if (any_reset && debug_attached)
         blocked_flag_ff <= 1'b1;
      else if (wr && paddr == `WDOG_OFF_INTR && pwdata[`WDOG_INTR_BLOCKED])
         blocked_flag_ff <= 1'b0;
   end

   // Registered reset request, one cycle per event
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_ff <= 1'b0;
      else
         reset_ff <= any_reset & ~debug_attached;
   end
   assign device_reset_req = reset_ff;

   // Masked match request plus unmasked blocked flag, routed by power mode
   assign irq_level = (match_interrupt_flag_ff & mask_ff) | blocked_flag_ff;
   assign cpu_irq = irq_level & (power_mode == wdog_pkg::pm_active);
   assign wic_irq = irq_level & ((power_mode == wdog_pkg::pm_sleep) ||
                    (power_mode == wdog_pkg::pm_deep_sleep));

   // New match values wait for the second slow edge after the write
   always_comb
   begin
      nxt_sync = sync_ff;
      unique case (sync_ff)
         wdog_pkg::sync_idle:
            nxt_sync = wdog_pkg::sync_idle;
         wdog_pkg::sync_first:
            nxt_sync = lf_tick ? wdog_pkg::sync_second : wdog_pkg::sync_first;
         wdog_pkg::sync_second:
            nxt_sync = lf_tick ? wdog_pkg::sync_idle : wdog_pkg::sync_second;
         default:
            nxt_sync = wdog_pkg::sync_idle;
      endcase
      if (wr && paddr == `WDOG_OFF_MC_MATCH)
         nxt_sync = wdog_pkg::sync_first;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_ff <= wdog_pkg::sync_idle;
      else
         sync_ff <= nxt_sync;
   end

   // Effective match copy loaded on the slow edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mc_match_eff_ff <= '0;
      else if (sync_ff == wdog_pkg::sync_second && lf_tick)
         mc_match_eff_ff <= mc_match_sw_ff;
   end

   // Two 16-bit counters, channel n in bits n*16 upward
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++)
      begin : g_chan
         assign mc_clear[gi] = wr & (paddr == `WDOG_OFF_MC_INTR) & pwdata[gi];
         mc_counter16 #(
            .CW(CW)
         ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .lf_tick(lf_tick),
            .enable(mc_en_ff[gi]),
            .cfg(mc_cfg_ff[gi]),
            .match_value(mc_match_eff_ff[gi*CW +: CW]),
            .flag_clear(mc_clear[gi]),
            .count(mc_count[gi*CW +: CW]),
            .int_flag(mc_flag[gi]),
            .reset_event(mc_reset[gi])
         );
      end
   endgenerate
   assign counter_interrupt_request = mc_flag;

endmodule
`default_nettype wire

// ---- watchdog_and_multicounter_timer_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdog_defines.svh"

module watchdog_and_multicounter_timer_assertions
#(
   parameter int CW = 16,
   parameter int CHANNELS = 2
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDOG_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Ticks and device state
   input wire logic osc_tick,
   input wire logic lf_tick,
   input wire logic debug_attached,
   input wire wdog_pkg::power_mode_t power_mode,
   // Watchdog outputs
   input wire logic cpu_irq,
   input wire logic wic_irq,
   input wire logic device_reset_req,
   input wire logic [CHANNELS-1:0] counter_interrupt_request,
   input wire logic osc_enable,
   input wire logic [1:0] lf_select
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Completed write, the only cause a register output may follow
   logic wr_done;
   assign wr_done = psel && penable && pwrite;

   // Reset pulses, their cause and their suppression
   a_debug_blocks_reset: assert property (debug_attached && $past(debug_attached) |-> !device_reset_req)
      else $error("device reset while probe attached");
   a_reset_one_pulse: assert property (device_reset_req |=> !device_reset_req)
      else $error("device reset longer than one cycle");
   a_reset_from_tick: assert property (device_reset_req |-> $past(osc_tick || lf_tick))
      else $error("device reset without a counter tick");
   // Interrupt routing by power state
   a_active_no_wic: assert property (power_mode == wdog_pkg::pm_active |-> !wic_irq)
      else $error("wakeup request in active mode");
   a_sleep_no_cpu: assert property
      (power_mode inside {wdog_pkg::pm_sleep, wdog_pkg::pm_deep_sleep} |-> !cpu_irq)
      else $error("cpu request while asleep");
   a_hib_quiet: assert property (power_mode == wdog_pkg::pm_hibernate |-> !cpu_irq && !wic_irq)
      else $error("interrupt routed in hibernate");
   // Protected clock controls move only on their own write
   a_osc_by_write: assert property ($changed(osc_enable) |-> $past(wr_done && paddr == `WDOG_OFF_OSC))
      else $error("oscillator enable changed without write");
   a_clksel_by_write: assert property ($changed(lf_select) |-> $past(wr_done && paddr == `WDOG_OFF_CLKSEL))
      else $error("clock select changed without write");
   // Multi-counter flag set by a tick, cleared by its write
   a_mc_flag_tick: assert property ($rose(counter_interrupt_request[0]) |-> $past(lf_tick))
      else $error("counter flag set without tick");
   a_mc_flag_clear: assert property
      ($fell(counter_interrupt_request[0]) |-> $past(wr_done && paddr == `WDOG_OFF_MC_INTR && pwdata[0]))
      else $error("counter flag cleared without write");
endmodule

bind watchdog_and_multicounter_timer watchdog_and_multicounter_timer_assertions #(.CW(CW), .CHANNELS(CHANNELS)) chk_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
   .lf_tick(lf_tick), .debug_attached(debug_attached), .power_mode(power_mode), .cpu_irq(cpu_irq),
   .wic_irq(wic_irq), .device_reset_req(device_reset_req), .counter_interrupt_request(counter_interrupt_request),
   .osc_enable(osc_enable), .lf_select(lf_select)
);

`default_nettype wire

// ---- watchdog_and_multicounter_timer_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdog_defines.svh"

module watchdog_and_multicounter_timer_tb_top;
   logic pclk, presetn, psel, penable, pwrite, osc_tick, lf_tick, debug_attached, smp;
   logic [`WDOG_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, cpu_irq, wic_irq, device_reset_req, osc_enable;
   logic [1:0] cir, lf_select;
   wdog_pkg::power_mode_t power_mode;
   logic [7:0] resets;
   logic [32:0] pv_now;
   logic [32:0] notes[$];
   logic [15:0] m;
   logic [1:0] codes[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
   logic [1:0] locks[6] = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h2, 2'h0};
   int mismatches, checks_done, cycles, seed, f;

   watchdog_and_multicounter_timer watchdog_and_multicounter_timer_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
      .lf_tick(lf_tick), .debug_attached(debug_attached), .power_mode(power_mode), .cpu_irq(cpu_irq),
      .wic_irq(wic_irq), .device_reset_req(device_reset_req), .counter_interrupt_request(cir),
      .osc_enable(osc_enable), .lf_select(lf_select)
   );

   // Pins gathered into one word so one note covers them all
   assign pv_now = {18'h0, resets, cpu_irq, wic_irq, cir, osc_enable, lf_select};

   function automatic logic [32:0] pv(input logic [7:0] r, input logic ci, input logic wi, input logic [1:0] c,
                                      input logic o, input logic [1:0] l);
      pv = {18'h0, r, ci, wi, c, o, l};
   endfunction

   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Request held until pready is seen high
   task automatic apb(input logic w, input logic [`WDOG_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [`WDOG_ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [`WDOG_ADDR_W-1:0] a, input logic [32:0] e);
      notes.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic pins(input logic [32:0] e);
      notes.push_back(e);
      @(posedge pclk);
      smp <= 1'b1;
      @(posedge pclk);
      smp <= 1'b0;
   endtask

   // Slow ticks are single-cycle pulses with a gap between
   task automatic tick(input int n, input logic lf);
      repeat (n)
      begin
         @(posedge pclk);
         if (lf)
            lf_tick <= 1'b1;
         else
            osc_tick <= 1'b1;
         @(posedge pclk);
         lf_tick <= 1'b0;
         osc_tick <= 1'b0;
      end
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Monitor: oldest note against each read or pin sample
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         check("read", {pslverr, prdata}, notes.pop_front());
      if (smp)
         check("pins", pv_now, notes.pop_front());
   end

   // Reset pulse count and hang guard
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (device_reset_req === 1'b1)
         resets <= resets + 8'h01;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, osc_tick, lf_tick, debug_attached, smp} = '0;
      paddr = '0;
      pwdata = '0;
      power_mode = wdog_pkg::pm_active;
      resets = '0;
      seed = 32'hc444;
      m = 16'($random(seed));
      f = int'(m & 16'h000f) + 1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      pins(pv(8'h0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
      rd(`WDOG_OFF_CTL, {1'b0, 32'hc000_0000});
      wr(`WDOG_OFF_OSC, 32'h8000_0000);
      wr(`WDOG_OFF_CLKSEL, 32'h0000_0002);
      pins(pv(8'h0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0));
      for (int i = 0; i < 6; i++)
      begin
         wr(`WDOG_OFF_CTL, {codes[i], 30'h0});
         rd(`WDOG_OFF_CTL, {1'b0, locks[i], 30'h0});
      end
      wr(`WDOG_OFF_OSC, 32'h8000_0000);
      wr(`WDOG_OFF_CLKSEL, 32'h0000_0002);
      wr(`WDOG_OFF_MATCH, {12'h0, 4'hf, m});
      wr(`WDOG_OFF_CTL, 32'h0000_0001);
      wr(`WDOG_OFF_CTL, 32'hc000_0001);
      wr(`WDOG_OFF_OSC, 32'h0);
      wr(`WDOG_OFF_CLKSEL, 32'h0);
      pins(pv(8'h0, 1'b0, 1'b0, 2'h0, 1'b1, 2'h2));
      rd(12'h0fc, {1'b1, 32'h0});
      // Ignore field above twelve: match on the low nibble only
      tick(f - 1, 1'b0);
      rd(`WDOG_OFF_INTR, {1'b0, 32'h0});
      tick(1, 1'b0);
      rd(`WDOG_OFF_INTR, {1'b0, 32'h1});
      pins(pv(8'h0, 1'b0, 1'b0, 2'h0, 1'b1, 2'h2));
      wr(`WDOG_OFF_MASK, 32'h1);
      pins(pv(8'h0, 1'b1, 1'b0, 2'h0, 1'b1, 2'h2));
      for (int i = 1; i < 4; i++)
      begin
         power_mode <= wdog_pkg::power_mode_t'(i);
         pins(pv(8'h0, 1'b0, i != 3, 2'h0, 1'b1, 2'h2));
      end
      power_mode <= wdog_pkg::pm_active;
      rd(`WDOG_OFF_CNT, {17'h0, 16'(f)});
      wr(`WDOG_OFF_INTR, 32'h1);
      rd(`WDOG_OFF_CNT, {17'h0, 16'(f)});
      tick(32, 1'b0);
      pins(pv(8'h0, 1'b1, 1'b0, 2'h0, 1'b1, 2'h2));
      tick(16, 1'b0);
      pins(pv(8'h1, 1'b1, 1'b0, 2'h0, 1'b1, 2'h2));
      rd(`WDOG_OFF_CNT, {17'h0, 16'(f + 48)});
      // Second reset in mid-run, then the same run with a probe
      @(posedge pclk);
      presetn <= 1'b0;
      debug_attached <= 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wr(`WDOG_OFF_CTL, 32'h4000_0000);
      wr(`WDOG_OFF_CTL, 32'h8000_0000);
      wr(`WDOG_OFF_OSC, 32'h8000_0000);
      wr(`WDOG_OFF_MATCH, {12'h0, 4'hf, m});
      wr(`WDOG_OFF_CTL, 32'h0000_0001);
      tick(f + 32, 1'b0);
      rd(`WDOG_OFF_INTR, {1'b0, 32'h3});
      pins(pv(8'h1, 1'b1, 1'b0, 2'h0, 1'b1, 2'h0));
      wr(`WDOG_OFF_INTR, 32'h3);
      debug_attached <= 1'b0;
      // Periodic use: flag cleared above, match set to hit on the fifth tick from here
      wr(`WDOG_OFF_MATCH, {16'h0, 16'(f + 36)});
      tick(4, 1'b0);
      rd(`WDOG_OFF_INTR, {1'b0, 32'h0});
      tick(1, 1'b0);
      rd(`WDOG_OFF_INTR, {1'b0, 32'h1});
      // Multi-counter: ch0 irq with clear, ch1 reset, free running
      wr(`WDOG_OFF_MC_MATCH, 32'h0005_0002);
      tick(2, 1'b1);
      wr(`WDOG_OFF_MC_CFG, 32'h0000_0205);
      wr(`WDOG_OFF_MC_CTL, 32'h0000_0101);
      tick(2, 1'b1);
      pins(pv(8'h1, 1'b0, 1'b0, 2'h0, 1'b1, 2'h0));
      tick(1, 1'b1);
      pins(pv(8'h1, 1'b0, 1'b0, 2'h1, 1'b1, 2'h0));
      rd(`WDOG_OFF_MC_CNT, {1'b0, 32'h0003_0000});
      tick(3, 1'b1);
      pins(pv(8'h2, 1'b0, 1'b0, 2'h1, 1'b1, 2'h0));
      rd(`WDOG_OFF_MC_CNT, {1'b0, 32'h0006_0000});
      wr(`WDOG_OFF_MC_INTR, 32'h3);
      wr(`WDOG_OFF_MC_CFG, 32'h0000_0007);
      pins(pv(8'h2, 1'b0, 1'b0, 2'h0, 1'b1, 2'h0));
      tick(6, 1'b1);
      pins(pv(8'h2, 1'b0, 1'b0, 2'h1, 1'b1, 2'h0));
      tick(3, 1'b1);
      pins(pv(8'h3, 1'b0, 1'b0, 2'h1, 1'b1, 2'h0));
      give_verdict();
   end
endmodule

`default_nettype wire

// ---- wdog_defines.svh ----
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// Register byte addresses on the APB
`define WDOG_ADDR_W 12
`define WDOG_OFF_CTL 12'h000
`define WDOG_OFF_CNT 12'h004
`define WDOG_OFF_MATCH 12'h008
`define WDOG_OFF_INTR 12'h00c
`define WDOG_OFF_MASK 12'h010
`define WDOG_OFF_OSC 12'h014
`define WDOG_OFF_CLKSEL 12'h018
`define WDOG_OFF_MC_CTL 12'h01c
`define WDOG_OFF_MC_CFG 12'h020
`define WDOG_OFF_MC_CNT 12'h024
`define WDOG_OFF_MC_MATCH 12'h028
`define WDOG_OFF_MC_INTR 12'h02c

// Field positions
`define WDOG_CTL_EN 0
`define WDOG_LOCK_HI 31
`define WDOG_LOCK_LO 30
`define WDOG_IGN_HI 19
`define WDOG_IGN_LO 16
`define WDOG_INTR_MATCH 0
`define WDOG_INTR_BLOCKED 1
`define WDOG_OSC_EN 31
`define WDOG_MC_EN1 8
`define WDOG_MC_CFG1 8

// Reset values and limits
`define WDOG_LOCK_RST 2'h3
`define WDOG_LOCK_CLR0 2'h1
`define WDOG_LOCK_CLR1 2'h2
`define WDOG_LOCK_SET 2'h3
`define WDOG_IGN_MAX 4'hc
`define WDOG_MISS_LIMIT 2'h2
`define WDOG_MATCH_RST 16'h0000

`endif

// ---- wdog_pkg.sv ----
package wdog_pkg;

   // Power state of the surrounding device
   typedef enum logic [1:0] {
      pm_active = 2'b00,
      pm_sleep = 2'b01,
      pm_deep_sleep = 2'b10,
      pm_hibernate = 2'b11
   } power_mode_t;

   // Action taken by a 16-bit multi-counter on a match
   typedef enum logic [1:0] {
      act_none = 2'b00,
      act_irq = 2'b01,
      act_reset = 2'b10,
      act_irq_then_reset = 2'b11
   } match_action_t;

   // Configuration of one 16-bit multi-counter channel
   typedef struct packed {
      logic clear_on_match;
      match_action_t match_action;
   } chan_cfg_t;

   // Staging of a new match value into the slow clock
   typedef enum logic [1:0] {
      sync_idle = 2'b00,
      sync_first = 2'b01,
      sync_second = 2'b10
   } match_sync_t;

endpackage
